// file: inc/afems_cfg.svh
`ifndef AFEMS_CFG_SVH
`define AFEMS_CFG_SVH

// Command codes carried in the first byte of a frame
`define AFEMS_CMD_RESET        8'h72
`define AFEMS_CMD_SHUTDOWN     8'h90
`define AFEMS_CMD_START        8'hAF
`define AFEMS_CMD_RESULT       8'h80
`define AFEMS_CMD_WRITE_REG    8'h4C

// Write-only register that triggers a temperature refresh
`define AFEMS_REG_TEMP_REFRESH 8'h3F
`define AFEMS_TEMP_REFRESH_VAL 8'h01

`define AFEMS_RESULT_W         24
`define AFEMS_RESULT_ZERO      24'h000000
`define AFEMS_CNT_W            16
`define AFEMS_TC_SHIFT         4

// Conversion period, one figure per converter
`define AFEMS_CLK_PERIOD_NS    10
`define AFEMS_CONV_TIME_NS     10000
`define AFEMS_CONV_CYCLES      ((`AFEMS_CONV_TIME_NS) / (`AFEMS_CLK_PERIOD_NS))

`endif

// file: inc/afems_pkg.sv
package afems_pkg;
`include "afems_cfg.svh"

	typedef logic [`AFEMS_RESULT_W-1:0] afems_word_t;

	typedef enum logic [3:0] {
		AFEMS_SHUT  = 4'b0001,
		AFEMS_FIRST = 4'b0010,
		AFEMS_RUN   = 4'b0100,
		AFEMS_TEMP  = 4'b1000
	} afems_state_e;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] addr;
		logic [7:0] data;
	} afems_cmd_s;

	// Per-frame serial state, cleared while the select is high
	typedef struct packed {
		logic [2:0]  bit_cnt;
		logic [1:0]  byte_cnt;
		logic [7:0]  shift_in;
		logic [7:0]  op;
		logic [7:0]  addr;
		afems_word_t tx;
		logic        tx_en;
	} afems_frame_s;

	// Command mailbox that survives between frames
	typedef struct packed {
		logic       tgl;
		afems_cmd_s cmd;
	} afems_link_s;

	typedef struct packed {
		afems_state_e             state;
		logic [`AFEMS_CNT_W-1:0]  conv_cnt;
		logic                     stop_pend;
		logic                     refresh_pend;
		afems_word_t              temp_ref;
		afems_word_t              hold;
		logic [1:0]               tgl_sync;
		logic                     tgl_seen;
		logic [1:0]               sel_sync;
	} afems_core_s;

endpackage

// file: logic/afems_fifo2.sv
`timescale 1ns/10ps
module afems_fifo2 #(
	parameter int W     = 24,
	parameter int DEPTH = 2
) (
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wr_ptr;
		logic [PW-1:0]           rd_ptr;
		logic [CW-1:0]           count;
	} afems_fifo_s;

	afems_fifo_s f_reg;
	afems_fifo_s f_next;
	logic        push;
	logic        pop;

	function automatic logic [PW-1:0] afems_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign in_ready_o  = (f_reg.count != CW'(DEPTH));
	assign out_valid_o = (f_reg.count != '0);
	assign out_data_o  = f_reg.mem[f_reg.rd_ptr];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		f_next = f_reg;
		if (flush_i) begin
			f_next.wr_ptr = '0;
			f_next.rd_ptr = '0;
			f_next.count  = '0;
		end else begin
			if (push) begin
				f_next.mem[f_reg.wr_ptr] = in_data_i;
				f_next.wr_ptr            = afems_inc(f_reg.wr_ptr);
			end
			if (pop) begin
				f_next.rd_ptr = afems_inc(f_reg.rd_ptr);
			end
			if (push && !pop) begin
				f_next.count = CW'(f_reg.count + 1'b1);
			end else if (pop && !push) begin
				f_next.count = CW'(f_reg.count - 1'b1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end
endmodule

// file: logic/afems_converter.sv
// Notes on behaviour
// R1 - Reset or shutdown command finishes conversion, stops
// R2 - Host sends stop to every converter
// R3 - After finishing, converter enters shutdown state
// R4 - Later results corrected with first-conversion temperature
// R5 - Host should refresh correction temperature regularly
// R6 - Refresh: write 0x01 to register temperature_refresh_trigger
// R7 - Refresh finishes conversion, reconverts temperature, stores
// R8 - Last result stays readable during refresh
// R9 - Host must not assume shared conversion period
// R10 - Result read returns last result, zero first
// R11 - Results are 24-bit two's complement
// R12 - Shutdown stays until a new start command
`timescale 1ns/10ps
`include "afems_cfg.svh"
module afems_converter #(
	parameter int CONV_CYCLES = `AFEMS_CONV_CYCLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  spi_clk_i,
	input  wire logic                  converter_select_n_i,
	input  wire logic                  serial_in_i,
	output logic                       converter_serial_output_o,
	output logic                       converter_serial_output_oe_n_o,
	input  wire afems_pkg::afems_word_t sensor_sample_i,
	input  wire afems_pkg::afems_word_t temperature_conversion_i,
	output logic                       shutdown_o,
	output logic                       temp_refresh_o
);
	import afems_pkg::*;

	afems_frame_s fr_reg;
	afems_frame_s fr_next;
	afems_link_s  lk_reg;
	afems_link_s  lk_next;
	afems_core_s  co_reg;
	afems_core_s  co_next;

	logic        frame_rst_n;
	logic        byte_done;
	logic [7:0]  byte_val;
	logic        evt;
	logic        is_stop;
	logic        is_start;
	logic        is_refresh;
	logic        conv_last;
	logic        conv_done;
	logic        push;
	logic        pop;
	logic        flush;
	afems_word_t push_data;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	afems_word_t fifo_out_data;

	function automatic afems_word_t afems_correct(input afems_word_t s, input afems_word_t t);
		return afems_word_t'(s - afems_word_t'($signed(t) >>> `AFEMS_TC_SHIFT)); // R11
	endfunction

	// Frame logic is held in reset whenever the select is high
	assign frame_rst_n = reset_n_i & ~converter_select_n_i;
	assign byte_done   = (fr_reg.bit_cnt == 3'h7);
	assign byte_val    = {fr_reg.shift_in[6:0], serial_in_i};

	always_comb begin
		fr_next          = fr_reg;
		fr_next.shift_in = byte_val;
		fr_next.bit_cnt  = 3'(fr_reg.bit_cnt + 3'h1);
		if (fr_reg.tx_en) begin
			fr_next.tx = {fr_reg.tx[`AFEMS_RESULT_W-2:0], 1'b0};
		end
		if (byte_done) begin
			if (fr_reg.byte_cnt != 2'h3) begin
				fr_next.byte_cnt = 2'(fr_reg.byte_cnt + 2'h1);
			end
			if (fr_reg.byte_cnt == 2'h0) begin
				fr_next.op = byte_val;
				if (byte_val == `AFEMS_CMD_RESULT) begin
					// Hold is frozen while select is low, so no sync needed
					fr_next.tx    = co_reg.hold; // R10
					fr_next.tx_en = 1'b1;
				end
			end else if (fr_reg.byte_cnt == 2'h1) begin
				fr_next.addr = byte_val;
			end
		end
	end

	always_ff @(posedge spi_clk_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			fr_reg <= '0;
		end else begin
			fr_reg <= fr_next;
		end
	end

	always_comb begin
		lk_next = lk_reg;
		if (byte_done && fr_reg.byte_cnt == 2'h0 &&
			(byte_val == `AFEMS_CMD_RESET || byte_val == `AFEMS_CMD_SHUTDOWN ||
			byte_val == `AFEMS_CMD_START)) begin
			lk_next.cmd = '{code: byte_val, addr: 8'h00, data: 8'h00};
			lk_next.tgl = ~lk_reg.tgl;
		end else if (byte_done && fr_reg.byte_cnt == 2'h2 &&
			fr_reg.op == `AFEMS_CMD_WRITE_REG) begin
			lk_next.cmd = '{code: fr_reg.op, addr: fr_reg.addr, data: byte_val};
			lk_next.tgl = ~lk_reg.tgl;
		end
	end

	// Mailbox must not clear with the frame, or the toggle would fake an event
	always_ff @(posedge spi_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	assign converter_serial_output_o      = fr_reg.tx[`AFEMS_RESULT_W-1];
	assign converter_serial_output_oe_n_o = ~fr_reg.tx_en;

	// Command data is stable long before its toggle is seen here
	assign evt        = co_reg.tgl_sync[1] ^ co_reg.tgl_seen;
	assign is_stop    = evt && (lk_reg.cmd.code == `AFEMS_CMD_RESET ||
		lk_reg.cmd.code == `AFEMS_CMD_SHUTDOWN);
	assign is_start   = evt && lk_reg.cmd.code == `AFEMS_CMD_START;
	assign is_refresh = evt && lk_reg.cmd.code == `AFEMS_CMD_WRITE_REG &&
		lk_reg.cmd.addr == `AFEMS_REG_TEMP_REFRESH &&
		lk_reg.cmd.data == `AFEMS_TEMP_REFRESH_VAL;

	assign conv_last = (co_reg.conv_cnt == `AFEMS_CNT_W'(CONV_CYCLES - 1));
	// A full buffer stalls a sample conversion at its last cycle
	assign conv_done = conv_last && (co_reg.state == AFEMS_TEMP || fifo_in_ready);
	assign push      = conv_done && (co_reg.state == AFEMS_FIRST || co_reg.state == AFEMS_RUN);
	assign push_data = (co_reg.state == AFEMS_FIRST) ? sensor_sample_i :
		afems_correct(sensor_sample_i, co_reg.temp_ref); // R4
	assign flush     = is_start && co_reg.state == AFEMS_SHUT;
	assign pop       = fifo_out_valid && co_reg.sel_sync[1] && !flush;

	always_comb begin
		co_next          = co_reg;
		co_next.tgl_sync = {co_reg.tgl_sync[0], lk_reg.tgl};
		co_next.tgl_seen = co_reg.tgl_sync[1];
		co_next.sel_sync = {co_reg.sel_sync[0], converter_select_n_i};
		if (pop) begin
			co_next.hold = fifo_out_data; // R8 R10
		end
		if (co_reg.state != AFEMS_SHUT) begin
			if (is_stop) begin
				co_next.stop_pend = 1'b1; // R1
			end
			if (is_refresh) begin
				co_next.refresh_pend = 1'b1; // R7
			end
			if (!conv_last) begin
				co_next.conv_cnt = `AFEMS_CNT_W'(co_reg.conv_cnt + 1'b1);
			end
		end
		case (co_reg.state)
			AFEMS_SHUT: begin
				if (is_start) begin // R12
					co_next.state        = AFEMS_FIRST;
					co_next.conv_cnt     = '0;
					co_next.hold         = `AFEMS_RESULT_ZERO; // R10
					co_next.stop_pend    = 1'b0;
					co_next.refresh_pend = 1'b0;
				end
			end
			AFEMS_FIRST, AFEMS_RUN, AFEMS_TEMP: begin
				if (conv_done) begin
					co_next.conv_cnt = '0;
					if (co_reg.state != AFEMS_RUN) begin
						co_next.temp_ref = temperature_conversion_i; // R4 R7
					end
					if (co_reg.state == AFEMS_TEMP) begin
						co_next.refresh_pend = is_refresh;
					end
					if (co_reg.stop_pend || is_stop) begin
						co_next.state     = AFEMS_SHUT; // R1 R3
						co_next.stop_pend = 1'b0;
					end else if (co_reg.state != AFEMS_TEMP &&
						(co_reg.refresh_pend || is_refresh)) begin
						co_next.state        = AFEMS_TEMP; // R7
						co_next.refresh_pend = 1'b0;
					end else begin
						co_next.state = AFEMS_RUN;
					end
				end
			end
			default: begin
				co_next.state = AFEMS_SHUT;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			co_reg          <= '0;
			co_reg.state    <= AFEMS_SHUT;
			co_reg.sel_sync <= 2'b11;
		end else begin
			co_reg <= co_next;
		end
	end

	assign shutdown_o     = (co_reg.state == AFEMS_SHUT);
	assign temp_refresh_o = (co_reg.state == AFEMS_TEMP);

	afems_fifo2 #(
		.W     (`AFEMS_RESULT_W),
		.DEPTH (2)
	) u_buf (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (flush),
		.in_valid_i  (push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (co_reg.sel_sync[1] && !flush),
		.out_data_o  (fifo_out_data)
	);

	property p_stop_shut;
		@(posedge clk_i) disable iff (!reset_n_i)
		(conv_done && co_reg.stop_pend && co_reg.state != AFEMS_SHUT) |=> shutdown_o;
	endproperty
	a_stop_shut: assert property (p_stop_shut) else $error("stop did not reach shutdown"); // R1

	property p_stop_finishes;
		@(posedge clk_i) disable iff (!reset_n_i)
		(co_reg.state == AFEMS_RUN && !conv_done) |=> !shutdown_o;
	endproperty
	a_stop_finishes: assert property (p_stop_finishes) else $error("conversion cut short"); // R3

	property p_shut_holds;
		@(posedge clk_i) disable iff (!reset_n_i)
		(shutdown_o && !is_start) |=> (shutdown_o && !push);
	endproperty
	a_shut_holds: assert property (p_shut_holds) else $error("left shutdown without start"); // R12

	property p_corrected;
		@(posedge clk_i) disable iff (!reset_n_i)
		(push && co_reg.state == AFEMS_RUN) |->
		push_data == afems_word_t'(sensor_sample_i -
		{{`AFEMS_TC_SHIFT{co_reg.temp_ref[23]}}, co_reg.temp_ref[23:`AFEMS_TC_SHIFT]});
	endproperty
	a_corrected: assert property (p_corrected) else $error("result not corrected"); // R4

	property p_first_temp;
		@(posedge clk_i) disable iff (!reset_n_i)
		(conv_done && co_reg.state == AFEMS_FIRST) |=>
		co_reg.temp_ref == $past(temperature_conversion_i);
	endproperty
	a_first_temp: assert property (p_first_temp) else $error("first temperature lost"); // R4

	property p_refresh_enter;
		@(posedge clk_i) disable iff (!reset_n_i)
		(conv_done && co_reg.state == AFEMS_RUN && co_reg.refresh_pend &&
		!co_reg.stop_pend && !is_stop) |=> temp_refresh_o;
	endproperty
	a_refresh_enter: assert property (p_refresh_enter) else $error("refresh not entered"); // R7

	property p_refresh_store;
		@(posedge clk_i) disable iff (!reset_n_i)
		(conv_done && co_reg.state == AFEMS_TEMP) |=>
		co_reg.temp_ref == $past(temperature_conversion_i);
	endproperty
	a_refresh_store: assert property (p_refresh_store) else $error("refresh not stored"); // R7

	// Assertion helper: bounds the refresh without a long delay range
	logic [`AFEMS_CNT_W-1:0] refresh_len_reg;
	logic [`AFEMS_CNT_W-1:0] refresh_len_next;

	assign refresh_len_next = temp_refresh_o ? `AFEMS_CNT_W'(refresh_len_reg + 1'b1) : '0;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			refresh_len_reg <= '0;
		end else begin
			refresh_len_reg <= refresh_len_next;
		end
	end

	property p_refresh_len;
		@(posedge clk_i) disable iff (!reset_n_i)
		temp_refresh_o |-> (refresh_len_reg < `AFEMS_CNT_W'(CONV_CYCLES));
	endproperty
	a_refresh_len: assert property (p_refresh_len) else $error("refresh overran"); // R7

	property p_refresh_keeps;
		@(posedge clk_i) disable iff (!reset_n_i)
		temp_refresh_o |-> !push;
	endproperty
	a_refresh_keeps: assert property (p_refresh_keeps) else $error("result pushed in refresh"); // R8

	property p_first_zero;
		@(posedge clk_i) disable iff (!reset_n_i)
		(co_reg.state == AFEMS_FIRST) |-> co_reg.hold == `AFEMS_RESULT_ZERO;
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("nonzero before first result"); // R10

	property p_hold_load;
		@(posedge clk_i) disable iff (!reset_n_i)
		(pop && !flush) |=> co_reg.hold == $past(fifo_out_data);
	endproperty
	a_hold_load: assert property (p_hold_load) else $error("result not latched"); // R10

endmodule

// file: test/afems_host_model.sv
`timescale 1ns/10ps
`include "afems_cfg.svh"
module afems_host_model (
	output logic      spi_clk_o,
	output logic      select_n_o,
	output logic      serial_o,
	input  wire logic serial_output_i,
	input  wire logic serial_output_oe_n_i
);
	import afems_pkg::*;
	localparam int HALF = 80;

	initial begin
		spi_clk_o = 1'b0;
		select_n_o = 1'b1;
		serial_o = 1'b0;
	end

	// Clock idles low between frames; data line flips so idle is never a bit
	task automatic frame(input afems_cmd_s cmd, input int nbits, output afems_word_t rx);
		logic [23:0] sh;
		rx = '0;
		sh = cmd;
		#57;
		select_n_o = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			serial_o = sh[23];
			sh = {sh[22:0], 1'b0};
			#HALF spi_clk_o = 1'b1;
			#HALF spi_clk_o = 1'b0;
			if (i >= 7) begin
				rx = {rx[22:0], (serial_output_oe_n_i === 1'b0) ? serial_output_i : 1'bx};
			end
		end
		#HALF select_n_o = 1'b1;
		serial_o = ~serial_o;
	endtask

	task automatic start();
		afems_word_t rx;
		frame({`AFEMS_CMD_START, 16'h0000}, 8, rx);
	endtask

	// Only one converter here, so every stop reaches all of them
	task automatic stop(input logic [7:0] code);
		afems_word_t rx;
		frame({code, 16'h0000}, 8, rx);
	endtask

	task automatic refresh();
		afems_word_t rx;
		frame({`AFEMS_CMD_WRITE_REG, `AFEMS_REG_TEMP_REFRESH, `AFEMS_TEMP_REFRESH_VAL}, 24, rx);
	endtask

	// Shutdown and refresh waits are paced by the converter's flags, not by a shared period
	task automatic read(output afems_word_t rx);
		frame({`AFEMS_CMD_RESULT, 16'h0000}, 31, rx);
	endtask
endmodule

// file: test/afems_converter_tb.sv
`timescale 1ns/10ps
module afems_converter_tb;
	import afems_pkg::*;
	// Long enough that a read latches before the first result lands
	localparam int CONV = 200;
	logic        clk_i;
	logic        reset_n_i;
	logic        spi_clk;
	logic        sel_n;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe_n;
	logic        shutdown_o;
	logic        temp_refresh_o;
	afems_word_t sample;
	afems_word_t temp;
	afems_word_t tref;
	afems_word_t got;
	afems_word_t last;
	int          bad_count;
	int          check_count;

	afems_converter #(.CONV_CYCLES(CONV)) u_afems_converter (
		.clk_i                          (clk_i),
		.reset_n_i                      (reset_n_i),
		.spi_clk_i                      (spi_clk),
		.converter_select_n_i           (sel_n),
		.serial_in_i                    (sdi),
		.converter_serial_output_o      (sdo),
		.converter_serial_output_oe_n_o (sdo_oe_n),
		.sensor_sample_i                (sample),
		.temperature_conversion_i       (temp),
		.shutdown_o                     (shutdown_o),
		.temp_refresh_o                 (temp_refresh_o)
	);

	afems_host_model u_afems_host_model (
		.spi_clk_o            (spi_clk),
		.select_n_o           (sel_n),
		.serial_o             (sdi),
		.serial_output_i      (sdo),
		.serial_output_oe_n_i (sdo_oe_n)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic stop_test();
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input afems_word_t g, input afems_word_t e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	function automatic afems_word_t corr(input afems_word_t s, input afems_word_t t);
		return s - {{4{t[23]}}, t[23:4]};
	endfunction

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Bounded wait on shutdown (which=0) or refresh (which=1)
	task automatic wait_level(input int which, input logic v);
		for (int k = 0; k < 300; k++) begin
			if (((which == 1) ? temp_refresh_o : shutdown_o) === v) break;
			cycles(1);
		end
		check({23'h0, (which == 1) ? temp_refresh_o : shutdown_o}, {23'h0, v});
	endtask

	task automatic t_reset_state();
		check({21'h0, shutdown_o, temp_refresh_o, sdo_oe_n}, 24'h000005);
	endtask

	task automatic t_start();
		u_afems_host_model.start();
		tref = temp;
		cycles(5);
		check({23'h0, shutdown_o}, 24'h000000);
		u_afems_host_model.read(got);
		check(got, 24'h000000);
	endtask

	// Long read frames also fill the buffer and stall conversion
	task automatic t_correct();
		cycles(60);
		u_afems_host_model.read(got);
		check(got, corr(sample, tref));
		temp = temp + 24'h000300;
		cycles(60);
		u_afems_host_model.read(got);
		check(got, corr(sample, tref));
	endtask

	task automatic t_refresh();
		temp = 24'h000200;
		u_afems_host_model.refresh();
		wait_level(1, 1'b1);
		u_afems_host_model.read(got);
		check(got, corr(sample, tref));
		tref = temp;
		wait_level(1, 1'b0);
		cycles(60);
		u_afems_host_model.read(got);
		check(got, corr(sample, tref));
	endtask

	task automatic t_stop(input logic [7:0] code);
		u_afems_host_model.stop(code);
		wait_level(0, 1'b1);
		last = corr(sample, tref);
		sample = sample + 24'h000111;
		cycles(100);
		u_afems_host_model.read(got);
		check(got, last);
	endtask

	initial begin
		bad_count = 0;
		check_count = 0;
		reset_n_i = 1'b0;
		sample = 24'hFF63C0;
		temp = 24'h000100;
		tref = temp;
		repeat (8) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		cycles(3);
		t_reset_state();
		t_start();
		t_correct();
		t_refresh();
		t_stop(8'h72);
		t_start();
		t_correct();
		t_stop(8'h90);
		stop_test();
	end

	initial begin
		#400000;
		bad_count++;
		stop_test();
	end
endmodule
